// ===== bench/cbspd_ctl_chk.sv
// concurrent checks on the ports of the clock buffer control block
`timescale 1ns/1ps
module cbspd_ctl_chk #(
	parameter logic [17:0] LOCK_CYCLES = 18'h00014,
	parameter logic [17:0] WAKE_CYCLES = 18'h00014,
	parameter logic [17:0] HOLD_CYCLES = 18'h00190
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// power good
	input wire logic power_good_in,
	// outputs
	input wire logic [cbspd_pkg::NUM_OUT-1:0] diff_clock_out_p,
	input wire logic [cbspd_pkg::NUM_OUT-1:0] diff_clock_out_n,
	input wire logic osc_enable,
	input wire logic pll_narrow_band,
	input wire logic pll_wide_band,
	input wire logic pll_bypass,
	input wire logic freq_sel_100m,
	// bus enables
	input wire logic smb_scl_oe,
	input wire logic smb_sda_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [17:0] hold_cnt;
	logic [17:0] dark_cnt;
	logic seen_run;
	logic dark;
	assign dark = power_good_in && diff_clock_out_p == '0;
	// length of one unbroken pull on the data line
	always_ff @(posedge core_clk) begin
		if (!rst_n || !smb_sda_oe) hold_cnt <= 18'h00000;
		else hold_cnt <= hold_cnt + 18'h00001;
	end
	// cycles with power good high and outputs quiet; run seen once
	always_ff @(posedge core_clk) begin
		if (!rst_n || !dark) dark_cnt <= 18'h00000;
		else dark_cnt <= dark_cnt + 18'h00001;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) seen_run <= 1'b0;
		else if (diff_clock_out_p != '0) seen_run <= 1'b1;
	end
	a_legs_exclusive: assert property (
		(diff_clock_out_p & diff_clock_out_n) == '0)
		else $error("both legs of an output high");
	a_osc_gates_out: assert property (
		!osc_enable |-> diff_clock_out_p == '0 && diff_clock_out_n == '0)
		else $error("outputs run with oscillator off");
	a_osc_off_order: assert property (
		$fell(osc_enable) |-> $past(diff_clock_out_p) == '0)
		else $error("oscillator stopped before outputs parked");
	a_park_on_pd: assert property (
		!power_good_in [*8] ##1 !power_good_in [*8] ##1
		!power_good_in [*8] ##1 !power_good_in [*8]
		|-> diff_clock_out_p == '0 && diff_clock_out_n == '0)
		else $error("outputs not parked during power-down");
	a_start_bound: assert property (
		seen_run ? dark_cnt <= WAKE_CYCLES + 18'h00010
		: dark_cnt <= LOCK_CYCLES + 18'h00010)
		else $error("outputs late after power good");
	a_sda_hold_max: assert property (
		hold_cnt <= HOLD_CYCLES)
		else $error("data line held low too long");
	a_no_stretch: assert property (!smb_scl_oe)
		else $error("bus clock driven");
	a_pd_bus_float: assert property (
		!power_good_in [*6] |-> !smb_sda_oe)
		else $error("data line driven in power-down");
	a_cfg_parked: assert property (
		$changed({freq_sel_100m, pll_narrow_band, pll_wide_band, pll_bypass})
		|-> $past(diff_clock_out_p) == '0)
		else $error("frequency or mode moved while running");
	a_mode_onehot: assert property (
		osc_enable ##1 osc_enable
		|-> $onehot({pll_narrow_band, pll_wide_band, pll_bypass}))
		else $error("pll mode outputs not one-hot");
endmodule : cbspd_ctl_chk

// ===== bench/cbspd_far_side.sv
// reference clock source and bus pull-ups at the far side
`timescale 1ns/1ps
module cbspd_far_side #(
	parameter int HALF = 4
) (
	// clock
	input wire logic core_clk,
	// reference control and level
	input wire logic ref_run,
	output logic ref_clk,
	// host and slave bus drivers
	input wire logic host_scl,
	input wire logic host_sda,
	input wire logic dut_scl_out,
	input wire logic dut_scl_oe,
	input wire logic dut_sda_out,
	input wire logic dut_sda_oe,
	// resolved bus lines
	output logic scl_line,
	output logic sda_line
);
	int cnt;
	initial begin
		ref_clk = 1'b0;
		cnt = 0;
	end
	// fixed-rate reference equal to the output rate, stands low when stopped
	always @(posedge core_clk) begin
		if (!ref_run || cnt == HALF - 1) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
		if (!ref_run) ref_clk <= 1'b0;
		else if (cnt == HALF - 1) ref_clk <= ~ref_clk;
	end
	// pull-ups: a line is low while any party pulls it
	assign scl_line = host_scl & ~(dut_scl_oe & ~dut_scl_out);
	assign sda_line = host_sda & ~(dut_sda_oe & ~dut_sda_out);
endmodule : cbspd_far_side

// ===== bench/testbench.sv
// self-checking bench of the clock buffer control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
	n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module testbench;
	localparam int Q = 6;
	logic core_clk, rst_n, pg, fstrap, ref_run, m_scl, m_sda;
	logic [1:0] a_hi, a_lo, bw;
	logic ref_clk, scl_line, sda_line;
	logic [cbspd_pkg::NUM_OUT-1:0] out_p, out_n;
	logic osc_en, nb, wb, byp, f100, scl_o, scl_oe, sda_o, sda_oe;
	int n_fail, num_checks;
	logic [31:0] rng;
	logic [7:0] atab [9];
	// reference model state
	logic m_freq, m_swen;
	logic [1:0] m_mode, m_sw;
	cbspd_ctl #(.LOCK_CYCLES(18'h00014), .WAKE_CYCLES(18'h00014),
		.HOLD_CYCLES(18'h00190)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.power_good_in(pg), .freq_select_strap(fstrap), .addr_strap_hi(a_hi),
		.addr_strap_lo(a_lo), .pll_bw_strap(bw), .ref_clk_in(ref_clk),
		.diff_clock_out_p(out_p), .diff_clock_out_n(out_n),
		.osc_enable(osc_en), .pll_narrow_band(nb), .pll_wide_band(wb),
		.pll_bypass(byp), .freq_sel_100m(f100), .smb_scl_in(scl_line),
		.smb_sda_in(sda_line), .smb_scl_out(scl_o), .smb_scl_oe(scl_oe),
		.smb_sda_out(sda_o), .smb_sda_oe(sda_oe));
	cbspd_far_side #(.HALF(4)) u_far (.core_clk(core_clk), .ref_run(ref_run),
		.ref_clk(ref_clk), .host_scl(m_scl), .host_sda(m_sda),
		.dut_scl_out(scl_o), .dut_scl_oe(scl_oe), .dut_sda_out(sda_o),
		.dut_sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));
	////////////////////////////////////////////////////////////////////////
	// model helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [1:0] tri_c(input int i);
		return (i == 0) ? cbspd_pkg::TRI_LOW
			: (i == 1) ? cbspd_pkg::TRI_MID : cbspd_pkg::TRI_HIGH;
	endfunction : tri_c
	// narrow, wide, bypass
	function automatic logic [2:0] bits_of(input logic [1:0] m);
		return {m == 2'h0, m == 2'h3, m == 2'h1};
	endfunction : bits_of
	function automatic logic [7:0] exp_reg();
		return {m_mode, 2'h0, m_swen, m_sw, m_freq};
	endfunction : exp_reg
	////////////////////////////////////////////////////////////////////////
	// bus host
	task automatic q();
		repeat (Q) @(posedge core_clk);
	endtask : q
	task automatic bitx(input logic b, output logic r);
		m_sda <= b;
		q();
		m_scl <= 1'b1;
		q();
		r = sda_line;
		q();
		m_scl <= 1'b0;
		q();
	endtask : bitx
	task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
		bitx(1'b1, a);
	endtask : byte_x
	task automatic start_c();
		m_sda <= 1'b1;
		q();
		m_scl <= 1'b1;
		q();
		m_sda <= 1'b0;
		q();
		m_scl <= 1'b0;
		q();
	endtask : start_c
	// byte read or write of index 0; ak set when every byte the host sent was acked
	task automatic xfer(input logic [7:0] ad, input logic rd,
		input logic [7:0] v, output logic [7:0] d, output logic ak);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		start_c();
		byte_x(ad, r, a0);
		byte_x({1'b1, cbspd_pkg::REG_PLL_CTL}, r, a1);
		if (rd) begin
			start_c();
			byte_x(ad | 8'h01, r, a2);
			byte_x(8'hFF, d, a3);
		end else begin
			byte_x(v, r, a2);
		end
		m_sda <= 1'b0;
		q();
		m_scl <= 1'b1;
		q();
		m_sda <= 1'b1;
		q();
		ak = ~(a0 | a1 | a2);
	endtask : xfer
	// bounded wait for running or for parked outputs with oscillator off
	task automatic wait_out(input logic run);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			@(negedge core_clk);
			ok = run ? (out_p !== '0)
				: (out_p === '0 && out_n === '0 && osc_en === 1'b0);
		end
		@(posedge core_clk);
		`CHK("outputs", 1'b1, ok)
	endtask : wait_out
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	// one power cycle with random straps and bandwidth code i
	task automatic round(input int i);
		logic [7:0] d;
		logic [7:0] ad;
		logic ak;
		int k;
		@(posedge core_clk);
		rng = xs(rng);
		k = (rng % 3) * 3 + (rng >> 8) % 3;
		rst_n <= 1'b0;
		pg <= 1'b0;
		ref_run <= 1'b1;
		a_hi <= tri_c(k / 3);
		a_lo <= tri_c(k % 3);
		bw <= tri_c(i);
		fstrap <= rng[16];
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (16) @(posedge core_clk);
		m_freq = rng[16];
		m_mode = tri_c(i);
		m_swen = cbspd_pkg::SW_EN_RST;
		m_sw = cbspd_pkg::SW_MODE_RST;
		ad = atab[k];
		pg <= 1'b1;
		wait_out(1'b1);
		`CHK("freq_sel", m_freq, f100)
		`CHK("pll_bits", bits_of(m_mode), {nb, wb, byp})
		xfer(ad, 1'b1, 8'h00, d, ak);
		`CHK("ack_own", 1'b1, ak)
		`CHK("reg_reset", exp_reg(), d)
		xfer(atab[(k + 1) % 9], 1'b1, 8'h00, d, ak);
		`CHK("ack_other", 1'b0, ak)
		xfer(8'h00, 1'b0, 8'h00, d, ak);
		`CHK("ack_gcall", 1'b0, ak)
		m_sw = tri_c((i + 1) % 3);
		m_swen = 1'b1;
		xfer(ad, 1'b0, {~m_mode, 2'h3, 1'b1, m_sw, ~m_freq}, d, ak);
		xfer(ad, 1'b1, 8'h00, d, ak);
		`CHK("reg_sw", exp_reg(), d)
		`CHK("pll_hold", bits_of(m_mode), {nb, wb, byp})
		a_hi <= ~a_hi;
		fstrap <= ~m_freq;
		bw <= tri_c((i + 2) % 3);
		pg <= 1'b0;
		wait_out(1'b0);
		xfer(ad, 1'b1, 8'h00, d, ak);
		`CHK("ack_pd", 1'b0, ak)
		ref_run <= 1'b0;
		repeat (20) @(posedge core_clk);
		ref_run <= 1'b1;
		repeat (16) @(posedge core_clk);
		pg <= 1'b1;
		wait_out(1'b1);
		`CHK("freq_kept", m_freq, f100)
		`CHK("pll_sw", bits_of(m_sw), {nb, wb, byp})
		xfer(ad, 1'b1, 8'h00, d, ak);
		`CHK("reg_kept", exp_reg(), d)
		$display("round %0d done", i);
	endtask : round
	////////////////////////////////////////////////////////////////////////
	// clock, main sequence and watchdog
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		rst_n = 1'b0;
		pg = 1'b0;
		fstrap = 1'b0;
		ref_run = 1'b0;
		m_scl = 1'b1;
		m_sda = 1'b1;
		a_hi = 2'h0;
		a_lo = 2'h0;
		bw = 2'h0;
		n_fail = 0;
		num_checks = 0;
		rng = 32'h00003319;
		atab = '{cbspd_pkg::ADDR_LL, cbspd_pkg::ADDR_LM, cbspd_pkg::ADDR_LH,
			cbspd_pkg::ADDR_ML, cbspd_pkg::ADDR_MM, cbspd_pkg::ADDR_MH,
			cbspd_pkg::ADDR_HL, cbspd_pkg::ADDR_HM, cbspd_pkg::ADDR_HH};
		for (int i = 0; i < 3; i++) round(i);
		stop_test();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		stop_test();
	end
endmodule : testbench
// checker attached to every instance of the control block
bind cbspd_ctl cbspd_ctl_chk #(.LOCK_CYCLES(LOCK_CYCLES),
	.WAKE_CYCLES(WAKE_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .power_good_in(power_good_in),
	.diff_clock_out_p(diff_clock_out_p), .diff_clock_out_n(diff_clock_out_n),
	.osc_enable(osc_enable), .pll_narrow_band(pll_narrow_band),
	.pll_wide_band(pll_wide_band), .pll_bypass(pll_bypass),
	.freq_sel_100m(freq_sel_100m), .smb_scl_oe(smb_scl_oe),
	.smb_sda_oe(smb_sda_oe));

// ===== rtl/cbspd_ctl.sv
// strap latch, power-down sequencing, output gating and bus slave
`timescale 1ns/1ps
module cbspd_ctl #(
	parameter logic [17:0] LOCK_CYCLES = 18'(cbspd_pkg::LOCK_CYCLES),
	parameter logic [17:0] WAKE_CYCLES = 18'(cbspd_pkg::WAKE_CYCLES),
	parameter logic [17:0] HOLD_CYCLES = 18'(cbspd_pkg::HOLD_CYCLES)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// straps and power good
	input wire logic power_good_in,
	input wire logic freq_select_strap,
	input wire logic [1:0] addr_strap_hi,
	input wire logic [1:0] addr_strap_lo,
	input wire logic [1:0] pll_bw_strap,
	// reference clock level
	input wire logic ref_clk_in,
	// differential outputs
	output logic [cbspd_pkg::NUM_OUT-1:0] diff_clock_out_p,
	output logic [cbspd_pkg::NUM_OUT-1:0] diff_clock_out_n,
	// oscillator and pll control
	output logic osc_enable,
	output logic pll_narrow_band,
	output logic pll_wide_band,
	output logic pll_bypass,
	output logic freq_sel_100m,
	// management bus, open drain
	input wire logic smb_scl_in,
	input wire logic smb_sda_in,
	output logic smb_scl_out,
	output logic smb_scl_oe,
	output logic smb_sda_out,
	output logic smb_sda_oe
);

	typedef enum {SEQ_WAIT_PG, SEQ_LOCK, SEQ_RUN, SEQ_PARK, SEQ_OFF,
		SEQ_WAKE} cbspd_seq_t;
	typedef enum {SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_CMD, SMB_CMD_ACK,
		SMB_WDATA, SMB_WDATA_ACK, SMB_RDATA, SMB_RDATA_ACK} cbspd_smb_t;

	cbspd_seq_t seq;
	cbspd_smb_t smb;
	cbspd_pkg::cbspd_cfg_t cfg;
	cbspd_pkg::cbspd_ctl_t ctl;
	logic [1:0] mode_applied;
	logic [17:0] timer;
	logic pd_seen;
	logic gate;
	logic ref_q, pll_q, src, src_prev;
	logic src_rise, src_fall, park_now, start_now;
	logic power_down_n;
	logic [7:0] next_addr;
	logic [1:0] next_mode;

	////////////////////////////////////////////////////////////////////////
	// after the first power good the pin is the power-down input
	assign power_down_n = power_good_in;

	// strap resolution into the slave address
	always_comb begin
		next_addr = cbspd_pkg::ADDR_MM;
		case ({addr_strap_hi, addr_strap_lo})
			{cbspd_pkg::TRI_LOW, cbspd_pkg::TRI_LOW}: next_addr = cbspd_pkg::ADDR_LL;
			{cbspd_pkg::TRI_LOW, cbspd_pkg::TRI_MID}: next_addr = cbspd_pkg::ADDR_LM;
			{cbspd_pkg::TRI_LOW, cbspd_pkg::TRI_HIGH}: next_addr = cbspd_pkg::ADDR_LH;
			{cbspd_pkg::TRI_MID, cbspd_pkg::TRI_LOW}: next_addr = cbspd_pkg::ADDR_ML;
			{cbspd_pkg::TRI_MID, cbspd_pkg::TRI_HIGH}: next_addr = cbspd_pkg::ADDR_MH;
			{cbspd_pkg::TRI_HIGH, cbspd_pkg::TRI_LOW}: next_addr = cbspd_pkg::ADDR_HL;
			{cbspd_pkg::TRI_HIGH, cbspd_pkg::TRI_MID}: next_addr = cbspd_pkg::ADDR_HM;
			{cbspd_pkg::TRI_HIGH, cbspd_pkg::TRI_HIGH}: next_addr = cbspd_pkg::ADDR_HH;
			default: next_addr = cbspd_pkg::ADDR_MM; // middle or undriven code
		endcase
	end

	// bandwidth strap into a mode code, odd code read as middle
	always_comb begin
		case (pll_bw_strap)
			cbspd_pkg::TRI_LOW: next_mode = cbspd_pkg::MODE_NARROW;
			cbspd_pkg::TRI_HIGH: next_mode = cbspd_pkg::MODE_WIDE;
			default: next_mode = cbspd_pkg::MODE_BYPASS;
		endcase
	end

	// straps caught once, at the first power good, kept until power off
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg <= '0;
		end else if (seq == SEQ_WAIT_PG && power_good_in) begin
			cfg.freq_100m <= freq_select_strap;
			cfg.pll_mode <= next_mode;
			cfg.smb_addr <= next_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reference path: bypass takes the sample, pll modes one more stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_q <= 1'b0;
			pll_q <= 1'b0;
			src <= 1'b0;
			src_prev <= 1'b0;
		end else begin
			ref_q <= ref_clk_in;
			pll_q <= ref_q;
			src <= (mode_applied == cbspd_pkg::MODE_BYPASS) ? ref_q : pll_q;
			src_prev <= src;
		end
	end

	assign src_rise = src & ~src_prev;
	assign src_fall = ~src & src_prev;

	// start and park both land on a falling edge of the source
	assign start_now = (seq == SEQ_LOCK || seq == SEQ_WAKE) && power_down_n
		&& timer == '0 && src_fall;
	assign park_now = (seq == SEQ_PARK) && src_fall;

	////////////////////////////////////////////////////////////////////////
	// power sequencing
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seq <= SEQ_WAIT_PG;
			timer <= '0;
			pd_seen <= 1'b0;
			gate <= 1'b0;
			osc_enable <= 1'b0;
			mode_applied <= cbspd_pkg::MODE_BYPASS;
			freq_sel_100m <= 1'b0;
		end else begin
			case (seq)
				SEQ_WAIT_PG: begin
					if (power_good_in) begin
						osc_enable <= 1'b1;
						timer <= LOCK_CYCLES;
						mode_applied <= next_mode;
						freq_sel_100m <= freq_select_strap;
						seq <= SEQ_LOCK;
					end
				end
				SEQ_LOCK, SEQ_WAKE: begin
					pd_seen <= 1'b0;
					if (!power_down_n) begin
						seq <= SEQ_OFF;
					end else if (timer != '0) begin
						timer <= timer - 18'h00001;
					end else if (start_now) begin // start at a fall
						gate <= 1'b1;
						seq <= SEQ_RUN;
					end
				end
				SEQ_RUN: begin
					if (src_rise) begin
						pd_seen <= ~power_down_n;
						if (!power_down_n && pd_seen) begin
							seq <= SEQ_PARK;
						end
					end
				end
				SEQ_PARK: begin
					if (src_fall) begin
						gate <= 1'b0;
						seq <= SEQ_OFF;
					end
				end
				SEQ_OFF: begin
					pd_seen <= 1'b0;
					osc_enable <= 1'b0; // outputs already low
					// restart picks up override and strap while gated
					mode_applied <= ctl.sw_en ? ctl.sw_mode : cfg.pll_mode;
					freq_sel_100m <= cfg.freq_100m;
					if (power_down_n) begin
						osc_enable <= 1'b1;
						timer <= WAKE_CYCLES;
						seq <= SEQ_WAKE;
					end
				end
				default: seq <= SEQ_WAIT_PG;
			endcase
		end
	end

	// mode decode onto the pll controls
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pll_narrow_band <= 1'b0;
			pll_wide_band <= 1'b0;
			pll_bypass <= 1'b0;
		end else begin
			pll_narrow_band <= (mode_applied == cbspd_pkg::MODE_NARROW);
			pll_wide_band <= mode_applied[1];
			pll_bypass <= (mode_applied == cbspd_pkg::MODE_BYPASS);
		end
	end

	// output legs; look-ahead keeps the first and last n phase whole
	genvar gi;
	generate
		for (gi = 0; gi < cbspd_pkg::NUM_OUT; gi = gi + 1) begin : g_out
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					diff_clock_out_p[gi] <= 1'b0;
					diff_clock_out_n[gi] <= 1'b0;
				end else begin
					diff_clock_out_p[gi] <= gate & src;
					diff_clock_out_n[gi] <= (gate | start_now) & ~park_now
						& ~src;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// management bus front end
	logic [1:0] line_clean;
	logic scl_c, sda_c, scl_prev, sda_prev;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic slave_live, hold_timeout;
	logic [17:0] hold_cnt;

	cbspd_glitch_filter u_filter (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.line_raw({smb_scl_in, smb_sda_in}),
		.line_clean(line_clean)
	);

	assign scl_c = line_clean[1];
	assign sda_c = line_clean[0];
	assign scl_rise = scl_c & ~scl_prev;
	assign scl_fall = ~scl_c & scl_prev;
	assign bus_start = scl_c & scl_prev & sda_prev & ~sda_c;
	assign bus_stop = scl_c & scl_prev & ~sda_prev & sda_c;
	assign slave_live = (seq != SEQ_WAIT_PG) && power_down_n;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_c;
			sda_prev <= sda_c;
		end
	end

	// watchdog on our own data drive
	always_ff @(posedge core_clk) begin
		if (!rst_n || !smb_sda_oe) begin
			hold_cnt <= '0;
		end else if (!hold_timeout) begin
			hold_cnt <= hold_cnt + 18'h00001;
		end
	end

	assign hold_timeout = (hold_cnt >= HOLD_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// slave protocol: byte and block read and write
	logic [7:0] rx, tx, rd_byte, rd_next, reg_byte0;
	logic [3:0] bit_cnt;
	logic rd_mode, byte_mode, first_data;
	logic [6:0] index;
	logic wr_pulse;
	logic [6:0] wr_index;
	logic [7:0] wr_data;
	logic send_count;

	// readback: latched mode on top, override and frequency below
	assign reg_byte0 = {cfg.pll_mode, 2'b00, ctl.sw_en, ctl.sw_mode,
		cfg.freq_100m};
	assign rd_byte = (index == cbspd_pkg::REG_PLL_CTL) ? reg_byte0 : 8'h00;
	assign send_count = first_data & ~byte_mode;
	assign rd_next = send_count ? cbspd_pkg::BLOCK_RD_COUNT : rd_byte;

	always_ff @(posedge core_clk) begin
		if (!rst_n || !slave_live || hold_timeout) begin
			smb <= SMB_IDLE;
			smb_sda_oe <= 1'b0;
			bit_cnt <= '0;
			rx <= '0;
			tx <= '0;
			rd_mode <= 1'b0;
			byte_mode <= 1'b0;
			first_data <= 1'b0;
			index <= '0;
			wr_pulse <= 1'b0;
			wr_index <= '0;
			wr_data <= '0;
		end else begin
			wr_pulse <= 1'b0;
			if (bus_start) begin
				smb <= SMB_ADDR;
				bit_cnt <= '0;
				smb_sda_oe <= 1'b0;
			end else if (bus_stop) begin
				smb <= SMB_IDLE;
				smb_sda_oe <= 1'b0;
			end else begin
				case (smb)
					SMB_IDLE: smb <= SMB_IDLE;
					SMB_ADDR, SMB_CMD, SMB_WDATA: begin
						if (scl_rise) begin
							rx <= {rx[6:0], sda_c};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == cbspd_pkg::BITS_PER_BYTE) begin
							bit_cnt <= '0;
							smb_sda_oe <= 1'b1;
							if (smb == SMB_ADDR) begin
								// no table entry is zero, so general call is ignored
								if (rx[7:1] == cfg.smb_addr[7:1]) begin
									rd_mode <= rx[0];
									smb <= SMB_ADDR_ACK;
								end else begin
									smb_sda_oe <= 1'b0;
									smb <= SMB_IDLE;
								end
							end else if (smb == SMB_CMD) begin
								index <= rx[6:0];
								byte_mode <= rx[cbspd_pkg::CMD_BYTE_BIT];
								first_data <= 1'b1;
								smb <= SMB_CMD_ACK;
							end else begin
								if (!send_count) begin
									wr_pulse <= 1'b1;
									wr_index <= index;
									wr_data <= rx;
									index <= index + 7'h01;
								end
								first_data <= 1'b0;
								smb <= SMB_WDATA_ACK;
							end
						end
					end
					SMB_ADDR_ACK: begin
						if (scl_fall) begin
							if (rd_mode) begin
								tx <= rd_next;
								smb_sda_oe <= ~rd_next[7];
								if (!send_count) begin
									index <= index + 7'h01;
								end
								first_data <= 1'b0;
								smb <= SMB_RDATA;
							end else begin
								smb_sda_oe <= 1'b0;
								smb <= SMB_CMD;
							end
						end
					end
					SMB_CMD_ACK, SMB_WDATA_ACK: begin
						if (scl_fall) begin
							smb_sda_oe <= 1'b0;
							smb <= SMB_WDATA;
						end
					end
					SMB_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt == cbspd_pkg::BITS_PER_BYTE - 4'h1) begin
								bit_cnt <= '0;
								smb_sda_oe <= 1'b0;
								smb <= SMB_RDATA_ACK;
							end else begin
								bit_cnt <= bit_cnt + 4'h1;
								tx <= {tx[6:0], 1'b0};
								smb_sda_oe <= ~tx[6];
							end
						end
					end
					SMB_RDATA_ACK: begin
						if (scl_rise && sda_c) begin
							smb <= SMB_IDLE; // master ends with a nak
						end else if (scl_fall) begin
							tx <= rd_byte;
							smb_sda_oe <= ~rd_byte[7];
							index <= index + 7'h01;
							smb <= SMB_RDATA;
						end
					end
					default: smb <= SMB_IDLE;
				endcase
			end
		end
	end

	// software override bits, kept through power-down
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctl.sw_en <= cbspd_pkg::SW_EN_RST;
			ctl.sw_mode <= cbspd_pkg::SW_MODE_RST;
		end else if (wr_pulse && wr_index == cbspd_pkg::REG_PLL_CTL) begin
			ctl.sw_en <= wr_data[cbspd_pkg::BIT_SW_EN];
			ctl.sw_mode <= {wr_data[cbspd_pkg::BIT_SW_MODE1],
				wr_data[cbspd_pkg::BIT_SW_MODE0]};
		end
	end

	// the slave never drives the clock line or a high data level
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			smb_scl_out <= 1'b0;
			smb_scl_oe <= 1'b0;
			smb_sda_out <= 1'b0;
		end else begin
			smb_scl_out <= 1'b0;
			smb_scl_oe <= 1'b0; // no stretching
			smb_sda_out <= 1'b0;
		end
	end

endmodule : cbspd_ctl

// ===== rtl/cbspd_glitch_filter.sv
// glitch filter for the two management bus lines
`timescale 1ns/1ps
module cbspd_glitch_filter (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// raw lines, bit 1 clock, bit 0 data
	input wire logic [1:0] line_raw,
	// filtered lines
	output logic [1:0] line_clean
);

	////////////////////////////////////////////////////////////////////////
	// per line: output follows only when every tap agrees
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
			logic [cbspd_pkg::FILT_TAPS-1:0] taps;
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					taps <= '1;
					line_clean[gi] <= 1'b1;
				end else begin
					taps <= {taps[cbspd_pkg::FILT_TAPS-2:0], line_raw[gi]};
					if (&taps) begin
						line_clean[gi] <= 1'b1;
					end else if (~|taps) begin
						line_clean[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule : cbspd_glitch_filter

// ===== rtl/cbspd_pkg.sv
// constants, codes and carrier types of the clock buffer control block
package cbspd_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int LOCK_TIME_US = 1800; // stable clocks strictly before this
	localparam int LOCK_CYCLES = LOCK_TIME_US * CYC_PER_US - 1;
	localparam int WAKE_TIME_US = 300; // parked outputs driven high before this
	localparam int WAKE_CYCLES = WAKE_TIME_US * CYC_PER_US - 1;
	localparam int HOLD_TIME_MS = 10; // longest bus line hold
	localparam int HOLD_CYCLES = HOLD_TIME_MS * CYC_PER_US * 1000 - 1;
	localparam int TIMER_W = 18;
	localparam int HOLD_W = 18;

	////////////////////////////////////////////////////////////////////////
	// outputs and filter
	localparam int NUM_OUT = 6;
	localparam int FILT_TAPS = 3;
	localparam int PD_EDGES = 2; // rising edges seen low before parking

	////////////////////////////////////////////////////////////////////////
	// tri-level strap codes
	localparam logic [1:0] TRI_LOW = 2'h0;
	localparam logic [1:0] TRI_MID = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h3;

	// pll mode codes, also readback bits 7 and 6
	localparam logic [1:0] MODE_NARROW = 2'h0;
	localparam logic [1:0] MODE_BYPASS = 2'h1;
	localparam logic [1:0] MODE_WIDE = 2'h3;

	// slave addresses by (high strap, low strap)
	localparam logic [7:0] ADDR_LL = 8'hD8;
	localparam logic [7:0] ADDR_LM = 8'hDA;
	localparam logic [7:0] ADDR_LH = 8'hDE;
	localparam logic [7:0] ADDR_ML = 8'hC2;
	localparam logic [7:0] ADDR_MM = 8'hC4;
	localparam logic [7:0] ADDR_MH = 8'hC6;
	localparam logic [7:0] ADDR_HL = 8'hCA;
	localparam logic [7:0] ADDR_HM = 8'hCC;
	localparam logic [7:0] ADDR_HH = 8'hCE;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [6:0] REG_PLL_CTL = 7'h00;
	localparam int BIT_FREQ = 0;
	localparam int BIT_SW_MODE0 = 1;
	localparam int BIT_SW_MODE1 = 2;
	localparam int BIT_SW_EN = 3;
	localparam logic [1:0] SW_MODE_RST = 2'h3;
	localparam logic SW_EN_RST = 1'b0;
	localparam int CMD_BYTE_BIT = 7; // set: byte access, clear: block access
	localparam logic [7:0] BLOCK_RD_COUNT = 8'h01;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic freq_100m;
		logic [1:0] pll_mode;
		logic [7:0] smb_addr;
	} cbspd_cfg_t;

	typedef struct packed {
		logic sw_en;
		logic [1:0] sw_mode;
	} cbspd_ctl_t;

endpackage : cbspd_pkg
